//--- design/emdd_regs.svh
// Register offsets, reset values and timing constants of the descriptor DMA.
`ifndef EMDD_REGS_SVH
`define EMDD_REGS_SVH
`define EMDD_OFF_TX_CLOSE     12'h18c
`define EMDD_OFF_RX_CLOSE     12'h190
`define EMDD_OFF_RX_OPEN      12'h1c4
`define EMDD_OFF_TX_OPEN      12'h1c8
`define EMDD_OFF_CTRL         12'h024
`define EMDD_OFF_TX_ACT       12'h014
`define EMDD_OFF_RX_ACT       12'h010
`define EMDD_OFF_INT_STAT     12'h004
`define EMDD_OFF_INT_MASK     12'h008
`define EMDD_OFF_FIFO_SIZE    12'h0ec
`define EMDD_BIT_RESET        0
`define EMDD_BIT_ACTIVE       24
`define EMDD_INT_LC           0
`define EMDD_INT_RL           1
`define EMDD_INT_UN           2
`define EMDD_FIFO_SIZE_RST    16'h00c0
`define EMDD_SLOT_BITS        516
`define EMDD_BD_READY_BIT     15
`define EMDD_BD_WRAP_BIT      13
`define EMDD_BD_STEP          32'h0000_0008
`endif

//--- design/emdd_pkg.sv
// Types shared by the descriptor DMA design.
package emdd_pkg;
    typedef enum logic [2:0]
    {
        EMDD_IDLE  = 3'b000,
        EMDD_FETCH = 3'b001,
        EMDD_WAIT  = 3'b010,
        EMDD_DATA  = 3'b011,
        EMDD_CLOSE = 3'b100
    } emdd_state_e;
endpackage

//--- design/emdd_ethernet_mac_descriptor_dma.sv
// Descriptor fetch, pointer registers and error interrupts of the MAC DMA.
// Behaviour
// - Unready transmit descriptor stops transmitter, clears active.
// - Transmit activation write resumes at open pointer.
// - Transmit open pointer register, read and write.
// - Transmit close pointer register, read and write.
// - Receive open pointer register, read and write.
// - Receive close pointer register, read and write.
// - Non-empty receive descriptor idles receiver; activation resumes.
// - Same-address reread served from line buffer.
// - Transmit fetches ahead until FIFO full.
// - Transmit FIFO size 192 bytes, programmable.
// - Separate late collision, retry, underrun events.
// - Repeated same error raises no new event.
// - Control reset bit soft-resets whole module.
// - Slot time 516 bit times, feeds backoff.
//
// Design decision made here: strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "emdd_regs.svh"

module emdd_ethernet_mac_descriptor_dma
    import emdd_pkg::*;
#(
    parameter int FIFO_BYTES = `EMDD_FIFO_SIZE_RST
)
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    output logic             mem_req,
    output logic      [31:0] mem_addr,
    input  wire logic        mem_ack,
    input  wire logic [31:0] mem_rdata,
    output logic             tx_word_valid,
    output logic      [31:0] tx_word,
    input  wire logic        tx_byte_drain,
    input  wire logic        tx_frame_done,
    input  wire logic        tx_late_coll,
    input  wire logic        tx_retry_limit,
    input  wire logic        tx_underrun,
    input  wire logic        rx_frame_start,
    output logic             rx_ready,
    output logic      [9:0]  slot_bits,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////
    // All state sits in one record, so both resets clear it in one place.
    typedef struct packed
    {
        emdd_state_e tx_st;
        emdd_state_e rx_st;
        logic        tx_active;
        logic        rx_active;
        logic        rx_own;
        logic [31:0] tx_open;
        logic [31:0] tx_close;
        logic [31:0] rx_open;
        logic [31:0] rx_close;
        logic [31:0] tx_data_ptr;
        logic [15:0] tx_len;
        logic [15:0] fifo_size;
        logic [15:0] fifo_fill;
        logic [2:0]  int_stat;
        logic [2:0]  int_mask;
        logic [2:0]  err_prev;
        logic        lb_valid;
        logic [31:0] lb_addr;
        logic [31:0] lb_data;
        logic        req;
        logic [31:0] addr;
        logic        rx_fetch;
        logic        word_valid;
        logic [31:0] word;
        logic [31:0] rdata;
    } emdd_state_s;

    emdd_state_s s_reg;
    emdd_state_s s_next;

    // A wrapped descriptor sends the pointer back to the ring's base.
    function automatic logic [31:0] next_bd(input logic [31:0] ptr,
                                            input logic        wrap,
                                            input logic [31:0] base);
        next_bd = wrap ? base : ptr + `EMDD_BD_STEP;
    endfunction

    // Ready on transmit and empty on receive share one bit position.
    function automatic logic bd_owned(input logic [31:0] bd);
        bd_owned = bd[`EMDD_BD_READY_BIT];
    endfunction

    logic        wr_hit;
    logic [31:0] fetched;
    logic        got;
    logic [2:0]  err_now;

    always_comb
    begin
        s_next = s_reg;
        s_next.word_valid = 1'b0;
        wr_hit = 1'b0;
        fetched = mem_rdata;
        got = 1'b0;
        err_now = {tx_underrun, tx_retry_limit, tx_late_coll};

        // Bus reads: data appears in the cycle after the strobe.
        s_next.rdata = 32'h0000_0000;
        if (reg_read)
        begin
            unique case (reg_addr)
                `EMDD_OFF_TX_OPEN:  s_next.rdata = s_reg.tx_open;
                `EMDD_OFF_TX_CLOSE: s_next.rdata = s_reg.tx_close;
                `EMDD_OFF_RX_OPEN:  s_next.rdata = s_reg.rx_open;
                `EMDD_OFF_RX_CLOSE: s_next.rdata = s_reg.rx_close;
                `EMDD_OFF_TX_ACT:
                    s_next.rdata[`EMDD_BIT_ACTIVE] = s_reg.tx_active;
                `EMDD_OFF_RX_ACT:
                    s_next.rdata[`EMDD_BIT_ACTIVE] = s_reg.rx_active;
                `EMDD_OFF_INT_STAT: s_next.rdata[2:0] = s_reg.int_stat;
                `EMDD_OFF_INT_MASK: s_next.rdata[2:0] = s_reg.int_mask;
                `EMDD_OFF_FIFO_SIZE: s_next.rdata[15:0] = s_reg.fifo_size;
                default:            s_next.rdata = 32'h0000_0000;
            endcase
        end

        // Memory answers, or line buffer hits that skip the bus entirely.
        // A reread of the same address returns stale data by design.
        if (s_reg.req && mem_ack)
        begin
            got = 1'b1;
            s_next.req = 1'b0;
            s_next.lb_valid = 1'b1;
            s_next.lb_addr = s_reg.addr;
            s_next.lb_data = mem_rdata;
        end

        // Transmit engine.
        unique case (s_reg.tx_st)
            EMDD_IDLE:
            begin
            end
            EMDD_FETCH:
            begin
                if (!s_reg.req && !s_reg.rx_fetch)
                begin
                    if (s_reg.lb_valid && s_reg.lb_addr == s_reg.tx_open)
                    begin
                        fetched = s_reg.lb_data;
                        got = 1'b1;
                        s_next.tx_st = EMDD_WAIT;
                        s_next.word = s_reg.lb_data;
                    end
                    else if (!got)
                    begin
                        s_next.req = 1'b1;
                        s_next.addr = s_reg.tx_open;
                        s_next.tx_st = EMDD_WAIT;
                    end
                end
            end
            EMDD_WAIT:
            begin
                // With no request in flight the descriptor came from the
                // line buffer and waits in the word register.
                if (s_reg.req)
                    fetched = mem_rdata;
                else
                    fetched = s_reg.word;
                if (!s_reg.req || (mem_ack && !s_reg.rx_fetch))
                begin
                    if (!bd_owned(fetched))
                    begin
                        s_next.tx_active = 1'b0;
                        s_next.tx_st = EMDD_IDLE;
                    end
                    else
                    begin
                        s_next.tx_len = fetched[31:16];
                        s_next.tx_data_ptr = s_reg.tx_open + 32'h0000_0004;
                        s_next.tx_open = next_bd(s_reg.tx_open,
                            fetched[`EMDD_BD_WRAP_BIT], s_reg.tx_close);
                        s_next.tx_st = EMDD_DATA;
                    end
                end
            end
            EMDD_DATA:
            begin
                // Data is fetched while the FIFO has room; a drained
                // byte frees room so the engine stays ahead.
                if (s_reg.req && mem_ack && !s_reg.rx_fetch)
                begin
                    s_next.word_valid = 1'b1;
                    s_next.word = mem_rdata;
                    s_next.fifo_fill = s_reg.fifo_fill + 16'h0004;
                    s_next.tx_len = (s_reg.tx_len > 16'h0004) ?
                        s_reg.tx_len - 16'h0004 : 16'h0000;
                    s_next.tx_data_ptr = s_reg.tx_data_ptr
                        + 32'h0000_0004;
                end
                else if (!s_reg.req && !s_reg.rx_fetch)
                begin
                    if (s_reg.tx_len == 16'h0000)
                        s_next.tx_st = EMDD_CLOSE;
                    else if (s_reg.fifo_fill + 16'h0004 <= s_reg.fifo_size)
                    begin
                        s_next.req = 1'b1;
                        s_next.addr = s_reg.tx_data_ptr;
                    end
                end
            end
            EMDD_CLOSE:
            begin
                // Fetch the next descriptor at once: one ahead of the wire.
                s_next.tx_st = EMDD_FETCH;
            end
            default:
                s_next.tx_st = EMDD_IDLE;
        endcase
        // The close pointer follows frames on the wire; a wrapped ring is
        // left to software, which reloads the pointer.
        if (tx_frame_done)
            s_next.tx_close = next_bd(s_reg.tx_close, 1'b0, s_reg.tx_close);
        if (tx_byte_drain && s_next.fifo_fill != 16'h0000)
            s_next.fifo_fill = s_next.fifo_fill - 16'h0001;

        // Receive engine: checks the empty bit of the next descriptor.
        unique case (s_reg.rx_st)
            EMDD_IDLE:
            begin
            end
            EMDD_FETCH:
            begin
                // A reread of the descriptor just fetched is answered by
                // the line buffer; the bus is not used.
                if (s_reg.lb_valid && s_reg.lb_addr == s_reg.rx_open)
                begin
                    if (!bd_owned(s_reg.lb_data))
                    begin
                        s_next.rx_active = 1'b0;
                        s_next.rx_own = 1'b0;
                        s_next.rx_st = EMDD_IDLE;
                    end
                    else
                    begin
                        s_next.rx_own = 1'b1;
                        s_next.rx_st = EMDD_DATA;
                    end
                end
                // One request at a time: wait while the transmit engine
                // is about to use or is using the bus for a descriptor.
                else if (!s_reg.req && s_reg.tx_st != EMDD_WAIT
                         && s_reg.tx_st != EMDD_FETCH)
                begin
                    s_next.req = 1'b1;
                    s_next.rx_fetch = 1'b1;
                    s_next.addr = s_reg.rx_open;
                    s_next.rx_st = EMDD_WAIT;
                end
            end
            EMDD_WAIT:
            begin
                if (mem_ack)
                begin
                    s_next.rx_fetch = 1'b0;
                    if (!bd_owned(mem_rdata))
                    begin
                        s_next.rx_active = 1'b0;
                        s_next.rx_own = 1'b0;
                        s_next.rx_st = EMDD_IDLE;
                    end
                    else
                    begin
                        s_next.rx_own = 1'b1;
                        s_next.rx_st = EMDD_DATA;
                    end
                end
            end
            EMDD_DATA:
            begin
                if (rx_frame_start)
                begin
                    s_next.rx_own = 1'b0;
                    s_next.rx_open = next_bd(s_reg.rx_open, 1'b0,
                        s_reg.rx_close);
                    s_next.rx_close = s_reg.rx_open;
                    s_next.rx_st = EMDD_FETCH;
                end
            end
            default:
                s_next.rx_st = EMDD_IDLE;
        endcase

        // Error events fire only on a new occurrence; a clean frame rearms.
        if (tx_frame_done)
            s_next.err_prev = err_now;
        s_next.int_stat = s_reg.int_stat;
        if (reg_write && reg_addr == `EMDD_OFF_INT_STAT)
            s_next.int_stat = s_reg.int_stat & ~reg_wdata[2:0];
        s_next.int_stat = s_next.int_stat
            | (err_now & ~s_reg.err_prev & {3{tx_frame_done}});

        // Register writes come after the engines, so a pointer written by
        // software wins over an engine update in the same cycle.
        if (reg_write)
        begin
            unique case (reg_addr)
                `EMDD_OFF_TX_OPEN:  s_next.tx_open = reg_wdata;
                `EMDD_OFF_TX_CLOSE: s_next.tx_close = reg_wdata;
                `EMDD_OFF_RX_OPEN:  s_next.rx_open = reg_wdata;
                `EMDD_OFF_RX_CLOSE: s_next.rx_close = reg_wdata;
                `EMDD_OFF_INT_MASK: s_next.int_mask = reg_wdata[2:0];
                `EMDD_OFF_FIFO_SIZE: s_next.fifo_size = reg_wdata[15:0];
                `EMDD_OFF_TX_ACT:
                begin
                    s_next.tx_active = 1'b1;
                    if (s_reg.tx_st == EMDD_IDLE)
                        s_next.tx_st = EMDD_FETCH;
                end
                `EMDD_OFF_RX_ACT:
                begin
                    s_next.rx_active = 1'b1;
                    if (s_reg.rx_st == EMDD_IDLE)
                        s_next.rx_st = EMDD_FETCH;
                end
                `EMDD_OFF_CTRL: wr_hit = reg_wdata[`EMDD_BIT_RESET];
                default:
                begin
                end
            endcase
        end

        // Soft reset: the whole module returns to its reset state.
        if (rst || wr_hit)
        begin
            s_next = '0;
            s_next.tx_st = EMDD_IDLE;
            s_next.rx_st = EMDD_IDLE;
            s_next.fifo_size = 16'(FIFO_BYTES);
        end
    end

    // Reset is folded into the next state, so no reset branch is needed.
    always_ff @(posedge clk)
    begin
        s_reg <= s_next;
    end

    ////////////////////////////////////////////////////////////////////////
    assign reg_rdata = s_reg.rdata;
    assign mem_req = s_reg.req;
    assign mem_addr = s_reg.addr;
    assign tx_word_valid = s_reg.word_valid;
    assign tx_word = s_reg.word;
    assign rx_ready = s_reg.rx_own;
    // The slot is longer than the standard one, so a collision just past
    // the standard window is still retried and the backoff runs longer.
    assign slot_bits = 10'(`EMDD_SLOT_BITS);
    // Level output: clearing the status bit or its mask drops it.
    assign irq = |(s_reg.int_stat & s_reg.int_mask);

endmodule
`default_nettype wire

//--- testbench/emdd_dma_monitor.sv
// Port-level assertions for the descriptor DMA.
`timescale 1ns/1ns
`default_nettype none
`include "emdd_regs.svh"
module emdd_dma_monitor (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic        mem_ack,
    input wire logic        tx_word_valid,
    input wire logic        tx_frame_done,
    input wire logic [9:0]  slot_bits,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Last address answered by memory; a soft reset empties the buffer.
    logic        lb_seen;
    logic [31:0] lb_last;
    always_ff @(posedge clk)
    begin
        if (rst || (reg_write && reg_addr == `EMDD_OFF_CTRL
            && reg_wdata[`EMDD_BIT_RESET]))
            lb_seen <= 1'b0;
        else if (mem_req && mem_ack)
        begin
            lb_seen <= 1'b1;
            lb_last <= mem_addr;
        end
    end
    property p_slot; slot_bits == 10'h204; endproperty
    a_slot: assert property (p_slot) else $error("slot time wrong");
    property p_req_hold;
        mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    // A refetch of the address just answered would bypass the line buffer.
    property p_linebuf;
        $rose(mem_req) |-> !lb_seen || mem_addr != lb_last;
    endproperty
    a_linebuf: assert property (p_linebuf) else $error("same line refetched");
    property p_rdata_idle; !reg_read |=> reg_rdata == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data stray");
    property p_unmapped;
        reg_read && reg_addr == 12'h100 |=> reg_rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
    property p_rst_quiet;
        $fell(rst) |-> !irq && !mem_req && !tx_word_valid;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("busy after reset");
    property p_mask_off;
        reg_write && reg_addr == `EMDD_OFF_INT_MASK && reg_wdata[2:0] == 3'h0
        |-> ##2 !irq;
    endproperty
    a_mask_off: assert property (p_mask_off) else $error("masked irq high");
    property p_irq_cause;
        $rose(irq) |-> $past(tx_frame_done) || $past(tx_frame_done, 2)
        || $past(reg_write) || $past(reg_write, 2);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq no cause");
endmodule
bind emdd_ethernet_mac_descriptor_dma emdd_dma_monitor u_mon (.clk(clk),
    .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .tx_word_valid(tx_word_valid), .tx_frame_done(tx_frame_done),
    .slot_bits(slot_bits), .irq(irq));
`default_nettype wire

//--- testbench/emdd_mem_model.sv
// System memory holding descriptors and frame data.
`timescale 1ns/1ns
`default_nettype none
module emdd_mem_model #(
    parameter int LAT = 2
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        mem_req,
    input wire logic [31:0] mem_addr,
    output logic            mem_ack,
    output logic     [31:0] mem_rdata
);
    logic [31:0] mem [0:255];
    logic [31:0] last;
    int          cnt;
    // All words start zero, so every descriptor is unowned until set.
    initial foreach (mem[i]) mem[i] = 32'h0;
    always_ff @(posedge clk)
    begin
        if (rst || !mem_req || mem_ack)
        begin
            cnt <= 0;
            mem_ack <= 1'b0;
            mem_rdata <= ~last;
        end
        else if (cnt == LAT)
        begin
            mem_ack <= 1'b1;
            mem_rdata <= mem[mem_addr[9:2]];
            last <= mem[mem_addr[9:2]];
        end
        else
            cnt <= cnt + 1;
    end
endmodule
`default_nettype wire

//--- testbench/emdd_ethernet_mac_descriptor_dma_tb_top.sv
// Register-level tests of the descriptor DMA.
`timescale 1ns/1ns
`default_nettype none
`include "emdd_regs.svh"
module emdd_ethernet_mac_descriptor_dma_tb_top;
    logic        clk, rst, reg_write, reg_read, mem_req, mem_ack, irq;
    logic        tx_word_valid, tx_byte_drain, tx_frame_done, rx_ready;
    logic        tx_late_coll, tx_retry_limit, tx_underrun, rx_frame_start;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_addr, mem_rdata, tx_word, d, lw;
    logic [9:0]  slot_bits;
    logic [11:0] offs [4] = '{`EMDD_OFF_TX_OPEN, `EMDD_OFF_TX_CLOSE,
                              `EMDD_OFF_RX_OPEN, `EMDD_OFF_RX_CLOSE};
    int          errors, n_checks, n_words, cyc;
    emdd_ethernet_mac_descriptor_dma u_emdd_ethernet_mac_descriptor_dma (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
        .mem_rdata(mem_rdata), .tx_word_valid(tx_word_valid),
        .tx_word(tx_word), .tx_byte_drain(tx_byte_drain),
        .tx_frame_done(tx_frame_done), .tx_late_coll(tx_late_coll),
        .tx_retry_limit(tx_retry_limit), .tx_underrun(tx_underrun),
        .rx_frame_start(rx_frame_start), .rx_ready(rx_ready),
        .slot_bits(slot_bits), .irq(irq));
    emdd_mem_model u_mem (.clk(clk), .rst(rst), .mem_req(mem_req),
        .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (tx_word_valid)
        begin
            n_words <= n_words + 1;
            lw <= tx_word;
        end
        if (cyc == 30000)
        begin
            errors = errors + 1;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(posedge clk);
        d = reg_rdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        chk(d, exp);
    endtask
    // Polls the active flag, then expects it clear.
    task automatic idle(input logic [11:0] a);
        for (int i = 0; i < 50; i++)
        begin
            rd(a);
            if (d[24] !== 1'b1) break;
        end
        chk(d & 32'h0100_0000, 32'h0);
    endtask
    task automatic frame(input logic [2:0] e);
        @(posedge clk);
        {tx_underrun, tx_retry_limit, tx_late_coll} <= e;
        tx_frame_done <= 1'b1;
        @(posedge clk);
        tx_frame_done <= 1'b0;
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {rst, reg_write, reg_read, reg_addr, reg_wdata} = {3'b100, 44'h0};
        {tx_byte_drain, tx_frame_done, rx_frame_start} = 3'h0;
        {tx_underrun, tx_retry_limit, tx_late_coll} = 3'h0;
        {errors, n_checks, n_words, cyc} = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc(`EMDD_OFF_FIFO_SIZE, 32'h0000_00c0);
        chk({22'h0, slot_bits}, 32'h0000_0204);
        rdc(`EMDD_OFF_INT_STAT, 32'h0);
        foreach (offs[i])
        begin
            wr(offs[i], 32'h00a0_0000 + offs[i]);
            rdc(offs[i], 32'h00a0_0000 + offs[i]);
        end
        wr(12'h100, 32'hffff_ffff);
        rdc(12'h100, 32'h0);
        wr(`EMDD_OFF_FIFO_SIZE, 32'h80);
        rdc(`EMDD_OFF_FIFO_SIZE, 32'h80);
        for (int i = 0; i < 3; i++)
        begin
            wr(`EMDD_OFF_INT_MASK, 32'h1 << i);
            frame(3'b001 << i);
            rdc(`EMDD_OFF_INT_STAT, 32'h1 << i);
            chk({31'h0, irq}, 32'h1);
            wr(`EMDD_OFF_INT_STAT, 32'h1 << i);
            frame(3'b001 << i);
            rdc(`EMDD_OFF_INT_STAT, 32'h0);
            frame(3'h0);
            frame(3'b001 << i);
            rdc(`EMDD_OFF_INT_STAT, 32'h1 << i);
            wr(`EMDD_OFF_INT_MASK, 32'h0);
            @(posedge clk);
            chk({31'h0, irq}, 32'h0);
            wr(`EMDD_OFF_INT_STAT, 32'h7);
        end
        wr(`EMDD_OFF_TX_OPEN, 32'h100);
        wr(`EMDD_OFF_TX_ACT, 32'h0);
        rdc(`EMDD_OFF_TX_ACT, 32'h0100_0000);
        idle(`EMDD_OFF_TX_ACT);
        u_mem.mem[8'h40] = 32'h0004_8000;
        u_mem.mem[8'h41] = 32'hc3c3_5a5a;
        wr(`EMDD_OFF_TX_ACT, 32'h0);
        idle(`EMDD_OFF_TX_ACT);
        chk(n_words, 32'h0);
        // Steer through an unowned spare descriptor to flush the line buffer.
        wr(`EMDD_OFF_TX_OPEN, 32'h180);
        wr(`EMDD_OFF_TX_CLOSE, 32'h180);
        wr(`EMDD_OFF_TX_ACT, 32'h0);
        idle(`EMDD_OFF_TX_ACT);
        wr(`EMDD_OFF_TX_OPEN, 32'h100);
        wr(`EMDD_OFF_TX_CLOSE, 32'h100);
        wr(`EMDD_OFF_TX_ACT, 32'h0);
        idle(`EMDD_OFF_TX_ACT);
        chk(n_words, 32'h1);
        chk(lw, 32'hc3c3_5a5a);
        rdc(`EMDD_OFF_TX_OPEN, 32'h108);
        wr(`EMDD_OFF_RX_OPEN, 32'h200);
        wr(`EMDD_OFF_RX_ACT, 32'h0);
        rdc(`EMDD_OFF_RX_ACT, 32'h0100_0000);
        idle(`EMDD_OFF_RX_ACT);
        // The descriptor is handed over, but the stale copy still rules.
        u_mem.mem[8'h80] = 32'h0000_8000;
        wr(`EMDD_OFF_RX_ACT, 32'h0);
        idle(`EMDD_OFF_RX_ACT);
        chk({31'h0, rx_ready}, 32'h0);
        wr(`EMDD_OFF_RX_OPEN, 32'h280);
        wr(`EMDD_OFF_RX_CLOSE, 32'h280);
        wr(`EMDD_OFF_RX_ACT, 32'h0);
        idle(`EMDD_OFF_RX_ACT);
        wr(`EMDD_OFF_RX_OPEN, 32'h200);
        wr(`EMDD_OFF_RX_CLOSE, 32'h200);
        wr(`EMDD_OFF_RX_ACT, 32'h0);
        repeat (8) @(posedge clk);
        chk({31'h0, rx_ready}, 32'h1);
        rdc(`EMDD_OFF_RX_ACT, 32'h0100_0000);
        @(posedge clk);
        rx_frame_start <= 1'b1;
        @(posedge clk);
        rx_frame_start <= 1'b0;
        idle(`EMDD_OFF_RX_ACT);
        chk({31'h0, rx_ready}, 32'h0);
        rdc(`EMDD_OFF_RX_OPEN, 32'h208);
        rdc(`EMDD_OFF_RX_CLOSE, 32'h200);
        wr(`EMDD_OFF_CTRL, 32'h1);
        rdc(`EMDD_OFF_TX_OPEN, 32'h0);
        rdc(`EMDD_OFF_FIFO_SIZE, 32'h0000_00c0);
        stop_test();
    end
endmodule
`default_nettype wire
